// *** hdl/fbswd_consts.svh ***
// Constants for the far-bus slave window decode block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FBSWD_CONSTS_SVH
`define FBSWD_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FBSWD_OFF_LCS 12'h004
`define FBSWD_OFF_STATUS 12'h008
`define FBSWD_OFF_IMG6_CTL 12'hFB8
`define FBSWD_OFF_IMG6_BASE 12'hFBC
`define FBSWD_OFF_IMG6_BOUND 12'hFC0
`define FBSWD_OFF_IMG6_OFFSET 12'hFC4
`define FBSWD_OFF_IMG7_CTL 12'hFCC
`define FBSWD_OFF_IMG7_BASE 12'hFD0
`define FBSWD_OFF_IMG7_BOUND 12'hFD4
`define FBSWD_OFF_IMG7_OFFSET 12'hFD8

// ----------------------------------------------------------------
// Control word fields and reset
// ----------------------------------------------------------------
`define FBSWD_CTL_MASK 32'hE0F7_00C3
`define FBSWD_CTL_RESET 32'h00F0_0000
`define FBSWD_CTL_EN 31
`define FBSWD_CTL_POSTED_WRITE_ENABLE 30
`define FBSWD_CTL_PREFETCH_READ_ENABLE 29
`define FBSWD_CTL_PGM_HI 23
`define FBSWD_CTL_PGM_LO 22
`define FBSWD_CTL_SUP_HI 21
`define FBSWD_CTL_SUP_LO 20
`define FBSWD_CTL_VAS_HI 18
`define FBSWD_CTL_VAS_LO 16
`define FBSWD_CTL_WIDE 7
`define FBSWD_CTL_LOCK 6
`define FBSWD_CTL_LAS_HI 1
`define FBSWD_CTL_LAS_LO 0
`define FBSWD_LCS_BME 2
`define FBSWD_WIN_RESET 16'h0000

// ----------------------------------------------------------------
// Space and modifier encodings, queue depth
// ----------------------------------------------------------------
`define FBSWD_VAS_A24 3'h1
`define FBSWD_VAS_A32 3'h2
`define FBSWD_VAS_USER1 3'h6
`define FBSWD_VAS_USER2 3'h7
`define FBSWD_AMHI_A24 3'h7
`define FBSWD_AMHI_A32 3'h1
`define FBSWD_AMHI_USER1 3'h2
`define FBSWD_AMHI_USER2 3'h3
`define FBSWD_AM_DATA 2'h1
`define FBSWD_AM_PROG 2'h2
`define FBSWD_LAS_MEM 2'h0
`define FBSWD_FIFO_DEPTH 32

`endif

// *** hdl/fbswd_pkg.sv ***
// Types shared by the far-bus slave window decode block.
// Assumes the constants header is on the include path.
package fbswd_pkg;
`include "fbswd_consts.svh"

  // ----------------------------------------------------------------
  // Request sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FBSWD_IDLE = 2'b00,
    FBSWD_POST = 2'b01,
    FBSWD_DIRECT = 2'b10,
    FBSWD_ACK = 2'b11
  } fbswd_state_t;

endpackage

// *** hdl/fbswd_top.sv ***
// Two inbound far-bus slave windows: APB registers, decode, translation, posted queue.
// Assumes far-bus requests come from logic on sys_clk and APB from a compliant master.
//
// Function
// R1 - Claim address when bits 31:16 are at or above base and below bound.
// R2 - Zero bound means no upper limit above the base.
// R3 - Claimed address plus window offset gives the local destination address.
// R4 - Software loads negative offsets as two's complement; adder wraps modulo.
// R5 - Only memory-space writes are posted; I/O and configuration writes are not.
// R6 - No image responds unless local bus master enable is set.
// R7 - Image enable gates all decoding; resets disabled.
// R8 - Posted write enable selects posting of writes; resets off.
// R9 - Prefetch read enable allows prefetching reads; resets off.
// R10 - Program/data selector filters modifier codes; resets to both.
// R11 - Privilege selector filters modifier codes; resets to both.
// R12 - Far address space field selects A24, A32, user1 or user2; resets zero.
// R13 - Wide transfer enable permits 64-bit local transactions; resets off.
// R14 - Lock enable holds local lock during read-modify-write cycles.
// R15 - Local address space field routes to memory, I/O or configuration.
// R16 - Low sixteen bits of window registers read zero and ignore writes.
// R17 - Translation adds on bits 31:16; bits 15:0 pass unchanged.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "fbswd_consts.svh"

// ----------------------------------------------------------------
// Posted-write queue
// ----------------------------------------------------------------
module fbswd_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Storage has no reset; valid flags guard stale words
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Flags follow the count so full and empty are exact
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
endmodule // fbswd_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module fbswd_top
  import fbswd_pkg::*;
#(
  parameter int FIFO_DEPTH = `FBSWD_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic far_valid,
  input wire logic [31:0] far_addr,
  input wire logic [5:0] far_am,
  input wire logic far_write,
  input wire logic far_rmw,
  input wire logic [31:0] far_wdata,
  output logic far_ack,
  output logic far_claimed,
  output logic [31:0] far_rdata,
  output logic dir_valid,
  input wire logic dir_ready,
  output logic [31:0] dir_addr,
  output logic dir_write,
  output logic [31:0] dir_wdata,
  output logic [1:0] dir_space,
  output logic dir_prefetch,
  output logic dir_wide,
  output logic dir_image,
  input wire logic [31:0] dir_rdata,
  output logic local_lock,
  output logic post_valid,
  input wire logic post_ready,
  output logic [31:0] post_addr,
  output logic [31:0] post_data,
  output logic post_wide,
  output logic post_image
);
  localparam int QW = 66;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  logic [31:0] ctl [2];
  logic [15:0] base [2];
  logic [15:0] bound [2];
  logic [15:0] offset [2];
  logic bus_master_enable;
  fbswd_state_t st;
  logic [1:0] hit;
  logic sel;
  logic [31:0] xlat;
  logic posted;
  logic [QW-1:0] lat_entry;
  logic q_in_ready;
  logic q_out_valid;
  logic [QW-1:0] q_out_data;
  logic [CW-1:0] q_count;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [31:0] post_wdata_hold;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  assign apb_wr = psel & penable & pready & pwrite;

  // Read decode; low window bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `FBSWD_OFF_LCS: rd_mux[`FBSWD_LCS_BME] = bus_master_enable;
      `FBSWD_OFF_STATUS: rd_mux = {21'h00_0000, local_lock, st, 2'h0, 6'(q_count)};
      `FBSWD_OFF_IMG6_CTL: rd_mux = ctl[0];
      `FBSWD_OFF_IMG6_BASE: rd_mux = {base[0], 16'h0000}; // R16
      `FBSWD_OFF_IMG6_BOUND: rd_mux = {bound[0], 16'h0000}; // R16
      `FBSWD_OFF_IMG6_OFFSET: rd_mux = {offset[0], 16'h0000}; // R16
      `FBSWD_OFF_IMG7_CTL: rd_mux = ctl[1];
      `FBSWD_OFF_IMG7_BASE: rd_mux = {base[1], 16'h0000}; // R16
      `FBSWD_OFF_IMG7_BOUND: rd_mux = {bound[1], 16'h0000}; // R16
      `FBSWD_OFF_IMG7_OFFSET: rd_mux = {offset[1], 16'h0000}; // R16
      default: rd_err = 1'b1;
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~pready & (penable | ~penable);
      if (psel & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= rd_err;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Control words keep only defined fields, reserved bits stay zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl[0] <= `FBSWD_CTL_RESET; // R7 R8 R9 R10 R11 R12 R13 R15
      ctl[1] <= `FBSWD_CTL_RESET; // R7 R8 R9 R10 R11 R12 R13 R15
      bus_master_enable <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == `FBSWD_OFF_IMG6_CTL) begin
        ctl[0] <= pwdata & `FBSWD_CTL_MASK;
      end
      if (paddr == `FBSWD_OFF_IMG7_CTL) begin
        ctl[1] <= pwdata & `FBSWD_CTL_MASK;
      end
      if (paddr == `FBSWD_OFF_LCS) begin
        bus_master_enable <= pwdata[`FBSWD_LCS_BME];
      end
    end
  end

  // Window registers hold bits 31:16 only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      base[0] <= `FBSWD_WIN_RESET;
      base[1] <= `FBSWD_WIN_RESET;
      bound[0] <= `FBSWD_WIN_RESET;
      bound[1] <= `FBSWD_WIN_RESET;
      offset[0] <= `FBSWD_WIN_RESET;
      offset[1] <= `FBSWD_WIN_RESET;
    end else if (apb_wr) begin
      case (paddr)
        `FBSWD_OFF_IMG6_BASE: base[0] <= pwdata[31:16]; // R16
        `FBSWD_OFF_IMG6_BOUND: bound[0] <= pwdata[31:16]; // R16
        `FBSWD_OFF_IMG6_OFFSET: offset[0] <= pwdata[31:16]; // R16
        `FBSWD_OFF_IMG7_BASE: base[1] <= pwdata[31:16]; // R16
        `FBSWD_OFF_IMG7_BOUND: bound[1] <= pwdata[31:16]; // R16
        `FBSWD_OFF_IMG7_OFFSET: offset[1] <= pwdata[31:16]; // R16
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Window decode and translation
  // ----------------------------------------------------------------
  // Image 6 wins if software programs overlapping windows
  always_comb begin
    logic [2:0] space;
    logic am_ok;
    logic in_range;
    space = 3'h0;
    am_ok = 1'b0;
    in_range = 1'b0;
    hit = 2'b00;
    case (far_am[5:3])
      `FBSWD_AMHI_A24: space = `FBSWD_VAS_A24;
      `FBSWD_AMHI_A32: space = `FBSWD_VAS_A32;
      `FBSWD_AMHI_USER1: space = `FBSWD_VAS_USER1;
      `FBSWD_AMHI_USER2: space = `FBSWD_VAS_USER2;
      default: space = 3'h0;
    endcase
    for (int i = 0; i < 2; i++) begin
      // User spaces carry no program/privilege meaning, so no filter
      if (space == `FBSWD_VAS_USER1 || space == `FBSWD_VAS_USER2) begin
        am_ok = 1'b1;
      end else begin
        am_ok = ((far_am[1:0] == `FBSWD_AM_DATA) & ctl[i][`FBSWD_CTL_PGM_LO]
              | (far_am[1:0] == `FBSWD_AM_PROG) & ctl[i][`FBSWD_CTL_PGM_HI]) // R10
              & (far_am[2] ? ctl[i][`FBSWD_CTL_SUP_HI] : ctl[i][`FBSWD_CTL_SUP_LO]); // R11
      end
      in_range = (far_addr[31:16] >= base[i]) // R1
               & ((bound[i] == 16'h0000) | (far_addr[31:16] < bound[i])); // R1 R2
      hit[i] = bus_master_enable & ctl[i][`FBSWD_CTL_EN] & in_range & am_ok // R6 R7
             & (space != 3'h0) & (space == ctl[i][`FBSWD_CTL_VAS_HI:`FBSWD_CTL_VAS_LO]); // R12
    end
  end

  assign sel = ~hit[0];
  // Offset is treated as signed by plain modular wrap
  assign xlat = {far_addr[31:16] + offset[sel], far_addr[15:0]}; // R3 R4 R17
  assign posted = far_write & ctl[sel][`FBSWD_CTL_POSTED_WRITE_ENABLE] // R8
                & (ctl[sel][`FBSWD_CTL_LAS_HI:`FBSWD_CTL_LAS_LO] == `FBSWD_LAS_MEM); // R5

  // ----------------------------------------------------------------
  // Request sequencer
  // ----------------------------------------------------------------
  // Master must drop far_valid at the edge that shows far_ack
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= FBSWD_IDLE;
      far_ack <= 1'b0;
      far_claimed <= 1'b0;
      far_rdata <= 32'h0000_0000;
      dir_valid <= 1'b0;
    end else begin
      case (st)
        FBSWD_IDLE: begin
          if (far_valid) begin
            if (hit == 2'b00) begin
              far_ack <= 1'b1;
              far_claimed <= 1'b0;
              st <= FBSWD_ACK;
            end else if (posted) begin
              st <= FBSWD_POST; // R5 R8
            end else begin
              dir_valid <= 1'b1;
              st <= FBSWD_DIRECT;
            end
          end
        end
        FBSWD_POST: begin
          // Stalls here while the queue is full
          if (q_in_ready) begin
            far_ack <= 1'b1;
            far_claimed <= 1'b1;
            st <= FBSWD_ACK;
          end
        end
        FBSWD_DIRECT: begin
          if (dir_ready) begin
            dir_valid <= 1'b0;
            far_ack <= 1'b1;
            far_claimed <= 1'b1;
            far_rdata <= dir_write ? 32'h0000_0000 : dir_rdata;
            st <= FBSWD_ACK;
          end
        end
        FBSWD_ACK: begin
          far_ack <= 1'b0;
          far_claimed <= 1'b0;
          st <= FBSWD_IDLE;
        end
        default: st <= FBSWD_IDLE;
      endcase
    end
  end

  // Request latched at take so outputs stay steady while waiting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dir_addr <= 32'h0000_0000;
      dir_write <= 1'b0;
      dir_wdata <= 32'h0000_0000;
      dir_space <= 2'h0;
      dir_prefetch <= 1'b0;
      dir_wide <= 1'b0;
      dir_image <= 1'b0;
      post_wdata_hold <= 32'h0000_0000;
    end else if (st == FBSWD_IDLE && far_valid && hit != 2'b00) begin
      dir_addr <= xlat; // R3
      dir_write <= far_write;
      dir_wdata <= far_wdata;
      dir_space <= ctl[sel][`FBSWD_CTL_LAS_HI:`FBSWD_CTL_LAS_LO]; // R15
      dir_prefetch <= ~far_write & ctl[sel][`FBSWD_CTL_PREFETCH_READ_ENABLE]; // R9
      dir_wide <= ctl[sel][`FBSWD_CTL_WIDE]; // R13
      dir_image <= sel;
      post_wdata_hold <= far_wdata;
    end
  end

  // Lock held from a locked claim until far_rmw drops, which can be after the far cycle ends
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      local_lock <= 1'b0;
    end else if (~far_rmw) begin
      local_lock <= 1'b0; // R14
    end else if (st == FBSWD_IDLE && far_valid && hit != 2'b00
                 && ctl[sel][`FBSWD_CTL_LOCK]) begin
      local_lock <= 1'b1; // R14
    end
  end

  // ----------------------------------------------------------------
  // Posted-write queue
  // ----------------------------------------------------------------
  assign lat_entry = {dir_image, dir_wide, dir_addr, post_wdata_hold};

  fbswd_fifo #(
    .WIDTH(QW),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(st == FBSWD_POST),
    .in_ready(q_in_ready),
    .in_data(lat_entry),
    .out_valid(q_out_valid),
    .out_ready(post_ready & ~post_valid),
    .out_data(q_out_data),
    .count(q_count)
  );

  // Output stage registers the head word; one word per two cycles
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      post_valid <= 1'b0;
      post_addr <= 32'h0000_0000;
      post_data <= 32'h0000_0000;
      post_wide <= 1'b0;
      post_image <= 1'b0;
    end else if (post_valid) begin
      if (post_ready) begin
        post_valid <= 1'b0;
      end
    end else if (q_out_valid && post_ready) begin
      post_valid <= 1'b1;
      post_image <= q_out_data[65];
      post_wide <= q_out_data[64];
      post_addr <= q_out_data[63:32];
      post_data <= q_out_data[31:0];
    end
  end
endmodule // fbswd_top

// *** verification/fbswd_props.sv ***
// Checker for the window decode block: port-level decode and handshake relations.
// Assumes binding to fbswd_top, one clock sys_clk, synchronous reset srst.
`timescale 1ns/1ps
`include "fbswd_consts.svh"
module fbswd_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] far_addr,
  input wire logic far_rmw,
  input wire logic far_ack,
  input wire logic far_claimed,
  input wire logic [31:0] far_rdata,
  input wire logic dir_valid,
  input wire logic dir_ready,
  input wire logic [31:0] dir_addr,
  input wire logic dir_write,
  input wire logic dir_prefetch,
  input wire logic [31:0] dir_rdata,
  input wire logic local_lock
);
  logic bme;

  // Shadow of bus master enable, so claims can be tied to it
  always_ff @(posedge sys_clk) begin
    if (srst)
      bme <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `FBSWD_OFF_LCS)
      bme <= pwdata[`FBSWD_LCS_BME];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  apb_answer_a: assert property (psel && !penable && !pready |=> pready)
    else $error("register access not answered after setup");
  claim_needs_master_a: assert property (far_ack && !bme |-> !far_claimed)
    else $error("claim while bus mastering is off");
  claim_with_ack_a: assert property (far_claimed |-> far_ack)
    else $error("claim flag outside acknowledge");
  ack_pulse_a: assert property (far_ack |=> !far_ack)
    else $error("acknowledge longer than one cycle");
  low_bits_a: assert property (dir_valid |-> dir_addr[15:0] == far_addr[15:0])
    else $error("low address bits altered");
  dir_hold_a: assert property (dir_valid && !dir_ready |=> dir_valid && $stable(dir_addr))
    else $error("local request dropped or changed");
  read_return_a: assert property (dir_valid && dir_ready && !dir_write |=>
    far_ack && far_claimed && far_rdata == $past(dir_rdata))
    else $error("read data not returned");
  write_no_prefetch_a: assert property (dir_valid && dir_write |-> !dir_prefetch)
    else $error("prefetch flag on a write");
  lock_release_a: assert property (local_lock && !far_rmw |=> !local_lock)
    else $error("lock held after locked cycle");
endmodule // fbswd_props

bind fbswd_top fbswd_props u_props (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .far_addr, .far_rmw, .far_ack, .far_claimed, .far_rdata, .dir_valid,
  .dir_ready, .dir_addr, .dir_write, .dir_prefetch, .dir_rdata, .local_lock);

// *** verification/fbswd_far_master.sv ***
// Far-bus master model: one slave cycle at a time, held until acknowledged.
// Assumes calls begin just after a rising edge of sys_clk.
`timescale 1ns/1ps
module fbswd_far_master (
  input wire logic sys_clk,
  input wire logic far_ack,
  input wire logic far_claimed,
  input wire logic [31:0] far_rdata,
  output logic far_valid = 1'b0,
  output logic [31:0] far_addr = 32'h0000_0000,
  output logic [5:0] far_am = 6'h00,
  output logic far_write = 1'b0,
  output logic far_rmw = 1'b0,
  output logic [31:0] far_wdata = 32'h0000_0000
);
  // One cycle; lock line is left as given so a locked sequence can span calls
  task automatic run(input logic [31:0] a, input logic [5:0] m, input logic w,
                     input logic r, input logic [31:0] d, output logic c, output logic [31:0] q);
    int n;
    n = 0;
    far_valid <= 1'b1;
    far_addr <= a;
    far_am <= m;
    far_write <= w;
    far_rmw <= r;
    far_wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (far_ack !== 1'b1 && n < 400);
    c = (n < 400) ? far_claimed : 1'bx;
    q = far_rdata;
    far_valid <= 1'b0;
    // Released address, modifier and data lines show the inverse so stale values never pass
    far_addr <= ~a;
    far_am <= ~m;
    far_wdata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule // fbswd_far_master

// *** verification/tb_far_bus_slave_window_decode.sv ***
// Bench for the window decode block: APB tasks, far-bus cycles, local responders.
// Assumes the design, the far-bus master model and the checker are compiled first.
`timescale 1ns/1ps
`include "fbswd_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_far_bus_slave_window_decode;
  localparam logic [11:0] C7 = `FBSWD_OFF_IMG7_CTL, B7 = `FBSWD_OFF_IMG7_BASE;
  localparam logic [11:0] N7 = `FBSWD_OFF_IMG7_BOUND, O7 = `FBSWD_OFF_IMG7_OFFSET;
  logic [11:0] win[6] = '{`FBSWD_OFF_IMG6_BASE, `FBSWD_OFF_IMG6_BOUND,
    `FBSWD_OFF_IMG6_OFFSET, B7, N7, O7};
  logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, dir_rdata = 32'h0000_0000, prdata, fq;
  logic dir_ready = 1'b0, post_ready = 1'b1, pready, pslverr, fc, perr;
  logic [31:0] far_addr, far_wdata, far_rdata, dir_addr, dir_wdata, post_addr, post_data;
  logic [5:0] far_am;
  logic [1:0] dir_space, ls;
  logic far_valid, far_write, far_rmw, far_ack, far_claimed, dir_valid, dir_write;
  logic dir_prefetch, dir_wide, dir_image, local_lock, post_valid, post_wide, post_image;
  logic [37:0] g;
  logic [65:0] pq[$];
  int err_total = 0, num_checks = 0, nd = 0, dw = 0, lat = 0, cyc = 0, n0, q0;

  fbswd_top #(.FIFO_DEPTH(4)) DUT (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .far_valid, .far_addr, .far_am, .far_write, .far_rmw,
    .far_wdata, .far_ack, .far_claimed, .far_rdata, .dir_valid, .dir_ready, .dir_addr,
    .dir_write, .dir_wdata, .dir_space, .dir_prefetch, .dir_wide, .dir_image, .dir_rdata,
    .local_lock, .post_valid, .post_ready, .post_addr, .post_data, .post_wide, .post_image);
  fbswd_far_master FM (.sys_clk, .far_ack, .far_claimed, .far_rdata, .far_valid, .far_addr,
    .far_am, .far_write, .far_rmw, .far_wdata);

  // Clock
  initial forever #4 sys_clk = ~sys_clk;

  // Local target answers after lat cycles with the inverted address; hang guard
  always @(posedge sys_clk) begin
    dw <= (dir_valid && !dir_ready) ? dw + 1 : 0;
    dir_ready <= dir_valid && !dir_ready && dw >= lat;
    dir_rdata <= ~dir_addr;
    if (dir_valid && dir_ready) begin
      g <= {dir_write, dir_space, dir_prefetch, dir_wide, dir_image, dir_addr};
      nd <= nd + 1;
    end
    if (post_valid && post_ready)
      pq.push_back({post_wide, post_image, post_addr, post_data});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    fq = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(perr, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(fq, e);
  endtask

  task automatic far(input logic [31:0] a, input logic [5:0] m, input logic w, input logic r,
                     input logic [31:0] d, input logic ec);
    FM.run(a, m, w, r, d, fc, fq);
    `CHK(fc, ec);
  endtask

  function automatic logic [31:0] mk(input logic [2:0] e, input logic [1:0] pg,
      input logic [1:0] su, input logic [2:0] vs, input logic [1:0] wl, input logic [1:0] la);
    return {e, 5'h00, pg, su, 1'b0, vs, 8'h00, wl, 4'h0, la};
  endfunction

  // Modifier filter case: window claims everything, only the filters decide
  task automatic flt(input logic [1:0] pg, input logic [1:0] su, input logic [2:0] vs,
                     input logic [5:0] m, input logic ec);
    wr(C7, mk(3'h4, pg, su, vs, 2'h0, 2'h0));
    far(32'h0000_1000, m, 1'b0, 1'b0, 32'h0000_0000, ec);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(C7, 32'h00F0_0000);
    foreach (win[i]) rd(win[i], 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK(perr, 1'b1);
    foreach (win[i]) begin
      wr(win[i], 32'hFFFF_FFFF);
      rd(win[i], 32'hFFFF_0000);
    end
    wr(C7, 32'hFFFF_FFFF);
    rd(C7, mk(3'h7, 2'h3, 2'h3, 3'h7, 2'h3, 2'h3));
    $display("test registers done");
    wr(C7, mk(3'h4, 2'h3, 2'h3, 3'h2, 2'h0, 2'h0));
    wr(B7, 32'h1000_0000);
    wr(N7, 32'h2000_0000);
    wr(O7, 32'hF000_0000);
    far(32'h1000_0000, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b0);
    wr(`FBSWD_OFF_LCS, 32'h0000_0004);
    far(32'h0FFF_FFFC, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b0);
    far(32'h1000_0000, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    far(32'h1FFF_FFFC, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    far(32'h2000_0000, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b0);
    wr(N7, 32'h0000_0000);
    far(32'hFFFF_FFFC, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    lat = 5;
    far(32'h1234_5678, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    `CHK(fq, 32'hFDCB_A987);
    `CHK(g, {6'h01, 32'h0234_5678});
    lat = 0;
    wr(C7, mk(3'h0, 2'h3, 2'h3, 3'h2, 2'h0, 2'h0));
    far(32'h1234_5678, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b0);
    $display("test decode done");
    wr(B7, 32'h0000_0000);
    flt(2'h1, 2'h3, 3'h2, 6'h09, 1'b1);
    flt(2'h1, 2'h3, 3'h2, 6'h0A, 1'b0);
    flt(2'h2, 2'h3, 3'h2, 6'h09, 1'b0);
    flt(2'h2, 2'h3, 3'h2, 6'h0A, 1'b1);
    flt(2'h0, 2'h3, 3'h2, 6'h09, 1'b0);
    flt(2'h3, 2'h1, 3'h2, 6'h0D, 1'b0);
    flt(2'h3, 2'h1, 3'h2, 6'h09, 1'b1);
    flt(2'h3, 2'h2, 3'h2, 6'h09, 1'b0);
    flt(2'h3, 2'h2, 3'h2, 6'h0D, 1'b1);
    flt(2'h3, 2'h3, 3'h1, 6'h3D, 1'b1);
    flt(2'h3, 2'h3, 3'h1, 6'h09, 1'b0);
    flt(2'h3, 2'h3, 3'h6, 6'h10, 1'b1);
    flt(2'h3, 2'h3, 3'h7, 6'h18, 1'b1);
    flt(2'h3, 2'h3, 3'h0, 6'h09, 1'b0);
    $display("test filters done");
    // Last pass has posting off, so even memory writes go direct
    for (int s = 0; s < 4; s++) begin
      ls = (s == 3) ? 2'h0 : 2'(s);
      wr(C7, mk({1'b1, s != 3, 1'b0}, 2'h3, 2'h3, 3'h2, 2'h2, ls));
      n0 = nd;
      q0 = pq.size();
      far(32'h1234_5678, 6'h09, 1'b1, 1'b0, 32'hA5A5_0000 + s, 1'b1);
      repeat (4) @(posedge sys_clk);
      `CHK(pq.size() - q0, (s == 0) ? 1 : 0);
      `CHK(nd - n0, (s == 0) ? 0 : 1);
      if (s == 0) `CHK(pq[q0], {2'h3, 32'h0234_5678, 32'hA5A5_0000});
      if (s != 0) `CHK(g, {1'b1, ls, 3'h3, 32'h0234_5678});
      if (s != 0) `CHK(dir_wdata, 32'hA5A5_0000 + s);
    end
    wr(C7, mk(3'h5, 2'h3, 2'h3, 3'h2, 2'h0, 2'h0));
    far(32'h1234_5678, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    `CHK(g[34], 1'b1);
    // Both images claim here; the lower-numbered one must take the cycle
    wr(`FBSWD_OFF_IMG6_CTL, mk(3'h4, 2'h3, 2'h3, 3'h2, 2'h0, 2'h0));
    wr(`FBSWD_OFF_IMG6_BOUND, 32'h0000_0000);
    far(32'hFFFF_1234, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    `CHK(g, {6'h00, 32'hFFFE_1234});
    $display("test routing done");
    wr(C7, mk(3'h4, 2'h3, 2'h3, 3'h2, 2'h1, 2'h0));
    far(32'h1000_0000, 6'h09, 1'b0, 1'b1, 32'h0000_0000, 1'b1);
    `CHK(local_lock, 1'b1);
    far(32'h1000_0000, 6'h09, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
    `CHK(local_lock, 1'b0);
    wr(C7, mk(3'h6, 2'h3, 2'h3, 3'h2, 2'h0, 2'h0));
    far(32'h1000_0000, 6'h09, 1'b0, 1'b1, 32'h0000_0000, 1'b1);
    `CHK(local_lock, 1'b0);
    // Queue of four fills with the sink stalled; the fifth write must wait
    post_ready <= 1'b0;
    q0 = pq.size();
    for (int i = 0; i < 4; i++) far(32'h1000_0000 + 4 * i, 6'h09, 1'b1, 1'b0, i, 1'b1);
    fork
      far(32'h1000_0010, 6'h09, 1'b1, 1'b0, 32'h0000_0004, 1'b1);
      begin
        repeat (30) @(posedge sys_clk);
        `CHK(far_valid, 1'b1);
        rd(`FBSWD_OFF_STATUS, 32'h0000_0104);
        post_ready <= 1'b1;
      end
    join
    repeat (20) @(posedge sys_clk);
    `CHK(pq.size() - q0, 5);
    for (int i = 0; i < 5; i++) `CHK(pq[q0 + i][31:0], 32'(i));
    $display("test lock and queue done");
    report_and_stop();
  end
endmodule // tb_far_bus_slave_window_decode
